// File: verilog/lhs_defs.svh
`ifndef LHS_DEFS_SVH
`define LHS_DEFS_SVH
// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define LHS_IDX_TERM      8'h10
`define LHS_IDX_FSCALE    8'h12
`define LHS_IDX_LEVEL     8'h13
`define LHS_IDX_LINK      8'h06
// line_termination_control fields
`define LHS_TERM_HOOK     0
`define LHS_TERM_PAR      1
`define LHS_TERM_DCT_LO   2
`define LHS_TERM_DCT_HI   3
`define LHS_TERM_CLAMP    4
`define LHS_TERM_IDLEMON  5
`define LHS_TERM_MODE     6
`define LHS_TERM_RESET    8'h08
// full_scale_control fields
`define LHS_FS_FULL       0
`define LHS_FS_HEADROOM   1
`define LHS_FS_RESET      8'h00
// link control fields
`define LHS_LINK_PDN      0
`define LHS_LINK_RESET    8'h01
// line_level_status fields, code in bits 4:0
`define LHS_LVL_PRESENT   5
`define LHS_LVL_READY     6
`define LHS_LVL_LINKUP    7
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LHS_CLK_PERIOD_NS 10
`define LHS_ID_CHECK_NS   1000
`define LHS_ID_CHECK_CYC  ((`LHS_ID_CHECK_NS + `LHS_CLK_PERIOD_NS - 1) / `LHS_CLK_PERIOD_NS)
`define LHS_OFFHOOK_SAMPLES 1548
`define LHS_GROUP_DELAY_SAMPLES 12
// ----------------------------------------------------------------
// sense scaling, inputs in quarter volt and quarter milliamp steps
// ----------------------------------------------------------------
`define LHS_V_ZERO_Q      10'd12
`define LHS_V_STEP_Q      10'd11
`define LHS_I_STEP_Q      10'd12
`define LHS_I_OVL_Q       10'd560
`define LHS_I_OVL_EU_Q    10'd216
`define LHS_CODE_MAX      5'h1F
`define LHS_CODE_I_TOP    5'h1E
`endif

// File: verilog/lhs_pkg.sv
package lhs_pkg;
  typedef enum logic [1:0] {
    LHS_DCT_LOWV  = 2'b00,
    LHS_DCT_JAPAN = 2'b01,
    LHS_DCT_FCC   = 2'b10,
    LHS_DCT_EURO  = 2'b11
  } lhs_dct_t;
  typedef enum logic [3:0] {
    LINK_OFF   = 4'b0001,
    LINK_CHECK = 4'b0010,
    LINK_UP    = 4'b0100,
    LINK_FAIL  = 4'b1000
  } lhs_link_st_t;
  typedef enum logic [2:0] {
    HOOK_ON     = 3'b001,
    HOOK_SETTLE = 3'b010,
    HOOK_READY  = 3'b100
  } lhs_hook_st_t;
  typedef enum logic [3:0] {
    SRC_NONE    = 4'b0001,
    SRC_VOLTAGE = 4'b0010,
    SRC_CURRENT = 4'b0100,
    SRC_MONITOR = 4'b1000
  } lhs_sense_src_t;
endpackage

// File: verilog/lhs_sense_coder.sv
`timescale 1ns/10ps
`include "lhs_defs.svh"
module lhs_sense_coder import lhs_pkg::*; (
  // measurements
  input  wire logic [9:0]     line_voltage,
  input  wire logic [9:0]     loop_current,
  input  wire logic [4:0]     monitor_data,
  // selection
  input  wire lhs_sense_src_t src,
  input  wire logic           euro_mode,
  // code
  output logic [4:0]          code
);
  // voltage: below 3 V is zero, then 2.75 V a count up to full scale
  function automatic logic [4:0] volt_code(input logic [9:0] v);
    logic [9:0] q;
    q = 10'h000;
    if (v < `LHS_V_ZERO_Q) begin
      volt_code = 5'h00;
    end else begin
      q = 10'((v - `LHS_V_ZERO_Q) / `LHS_V_STEP_Q) + 10'h001;
      volt_code = (q > 10'(`LHS_CODE_MAX)) ? `LHS_CODE_MAX : q[4:0];
    end
  endfunction

  // current: 3 mA a count, all ones reserved for overload
  function automatic logic [4:0] curr_code(input logic [9:0] i,
                                           input logic       eu);
    logic [9:0] q;
    logic       ovl;
    ovl = eu ? (i > `LHS_I_OVL_EU_Q) : (i > `LHS_I_OVL_Q);
    q   = i / `LHS_I_STEP_Q;
    if (ovl) begin
      curr_code = `LHS_CODE_MAX;
    end else if (q > 10'(`LHS_CODE_I_TOP)) begin
      curr_code = `LHS_CODE_I_TOP;
    end else begin
      curr_code = q[4:0];
    end
  endfunction

  // source select
  always_comb begin
    case (src)
      SRC_VOLTAGE: code = volt_code(line_voltage);
      SRC_CURRENT: code = curr_code(loop_current, euro_mode);
      SRC_MONITOR: code = monitor_data;
      default:     code = 5'h00;
    endcase
  end
endmodule

// File: verilog/lhs_ahb_slave.sv
`timescale 1ns/10ps
module lhs_ahb_slave (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // register side
  output logic [7:0]       rd_index,
  input  wire logic [7:0]  rd_data,
  input  wire logic        rd_hit,
  output logic             wr_en,
  output logic [7:0]       wr_index,
  output logic [7:0]       wr_data
);
  logic        wr_pend;
  logic [7:0]  wr_idx;
  logic        next_wr_pend;
  logic [7:0]  next_wr_idx;
  logic [31:0] next_hrdata;
  logic        take;
  logic        in_map;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rd_index  = haddr[9:2];
  assign wr_en     = wr_pend;
  assign wr_index  = wr_idx;
  assign wr_data   = hwdata[7:0];

  // address phase capture; read data registered for the data phase
  always_comb begin
    take         = hsel & htrans[1] & hready;
    in_map       = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0)
                   & (hsize == 3'h2);
    next_wr_pend = take & hwrite & in_map;
    next_wr_idx  = take ? haddr[9:2] : wr_idx;
    next_hrdata  = hrdata;
    if (take & ~hwrite) begin
      next_hrdata = (in_map & rd_hit) ? {24'h000000, rd_data} : 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      wr_pend <= next_wr_pend;
      wr_idx  <= next_wr_idx;
      hrdata  <= next_hrdata;
    end
  end
endmodule

// File: verilog/lhs_line_ctrl.sv
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "lhs_defs.svh"
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module lhs_line_ctrl import lhs_pkg::*; #(
  parameter logic [7:0] EXPECTED_PART_ID = 8'h5A // arbitrary value
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // line side inputs (asynchronous)
  input  wire logic [7:0]  part_id_pin,
  input  wire logic        line_present_pin,
  input  wire logic [9:0]  line_voltage_pin,
  input  wire logic [9:0]  loop_current_pin,
  input  wire logic [4:0]  monitor_data_pin,
  // sample rate strobe (same clock)
  input  wire logic        sample_tick,
  // link and line controls
  output logic             link_enable,
  output logic             link_fault,
  output logic             hook_drive,
  output logic             line_data_valid,
  output logic [1:0]       dc_termination_mode,
  output logic             parallel_operation,
  output logic             current_clamp,
  output logic             full_scale_high,
  output logic             line_headroom_select
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]     rd_index;
  logic [7:0]     rd_data;
  logic           rd_hit;
  logic           wr_en;
  logic [7:0]     wr_index;
  logic [7:0]     wr_data;
  logic [7:0]     term_ctl;
  logic [7:0]     fs_ctl;
  logic [7:0]     link_ctl;
  logic [7:0]     next_term_ctl;
  logic [7:0]     next_fs_ctl;
  logic [7:0]     next_link_ctl;
  logic [33:0]    sync1;
  logic [33:0]    sync2;
  logic [7:0]     part_id_s;
  logic           line_present_s;
  logic [9:0]     line_voltage_s;
  logic [9:0]     loop_current_s;
  logic [4:0]     monitor_data_s;
  lhs_link_st_t   link_st;
  lhs_link_st_t   next_link_st;
  logic [7:0]     id_cnt;
  logic [7:0]     next_id_cnt;
  lhs_hook_st_t   hook_st;
  lhs_hook_st_t   next_hook_st;
  logic [10:0]    settle_cnt;
  logic [10:0]    next_settle_cnt;
  lhs_sense_src_t sense_src;
  logic [4:0]     sense_code;
  logic [4:0]     next_sense_code;
  logic [4:0]     coder_out;
  logic           link_up;
  logic           seize;
  logic [7:0]     next_outs;
  logic [7:0]     outs;

  localparam logic [7:0]  ID_WAIT = 8'(`LHS_ID_CHECK_CYC);
  localparam logic [10:0] SETTLE_LAST =
    11'(`LHS_OFFHOOK_SAMPLES - 1);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  lhs_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_index  (rd_index),
    .rd_data   (rd_data),
    .rd_hit    (rd_hit),
    .wr_en     (wr_en),
    .wr_index  (wr_index),
    .wr_data   (wr_data)
  );

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // two stages; only the second stage is read by logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 34'h0;
      sync2 <= 34'h0;
    end else begin
      sync1 <= {part_id_pin, line_present_pin, line_voltage_pin,
                loop_current_pin, monitor_data_pin};
      sync2 <= sync1;
    end
  end

  assign part_id_s      = sync2[33:26];
  assign line_present_s = sync2[25];
  assign line_voltage_s = sync2[24:15];
  assign loop_current_s = sync2[14:5];
  assign monitor_data_s = sync2[4:0];

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // read decode; status register shows live block state
  function automatic logic [8:0] read_reg(input logic [7:0] idx);
    if (idx == `LHS_IDX_TERM) begin
      read_reg = {1'b1, term_ctl};
    end else if (idx == `LHS_IDX_FSCALE) begin
      read_reg = {1'b1, fs_ctl};
    end else if (idx == `LHS_IDX_LEVEL) begin
      read_reg = {1'b1, link_up, hook_st == HOOK_READY,
                  line_present_s, sense_code};
    end else if (idx == `LHS_IDX_LINK) begin
      read_reg = {1'b1, link_ctl};
    end else begin
      read_reg = 9'h000;
    end
  endfunction

  // process form so that register changes also refresh the read data
  always_comb begin
    {rd_hit, rd_data} = read_reg(rd_index);
  end

  // writes; the status index takes no write
  always_comb begin
    next_term_ctl = term_ctl;
    next_fs_ctl   = fs_ctl;
    next_link_ctl = link_ctl;
    if (wr_en) begin
      if (wr_index == `LHS_IDX_TERM) begin
        next_term_ctl = {1'b0, wr_data[6:0]};
      end else if (wr_index == `LHS_IDX_FSCALE) begin
        next_fs_ctl = {6'h00, wr_data[1:0]};
      end else if (wr_index == `LHS_IDX_LINK) begin
        next_link_ctl = {7'h00, wr_data[`LHS_LINK_PDN]};
      end else begin
        next_link_ctl = link_ctl;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      term_ctl <= `LHS_TERM_RESET;
      fs_ctl   <= `LHS_FS_RESET;
      link_ctl <= `LHS_LINK_RESET;
    end else begin
      term_ctl <= next_term_ctl;
      fs_ctl   <= next_fs_ctl;
      link_ctl <= next_link_ctl;
    end
  end

  // ----------------------------------------------------------------
  // isolation link start and identity check
  // ----------------------------------------------------------------
  // a failed check locks the link out until reset
  always_comb begin
    next_link_st = link_st;
    next_id_cnt  = id_cnt;
    case (link_st)
      LINK_OFF: begin
        next_id_cnt = 8'h00;
        if (!link_ctl[`LHS_LINK_PDN]) begin
          next_link_st = LINK_CHECK;
        end
      end
      LINK_CHECK: begin
        next_id_cnt = id_cnt + 8'h01;
        if (link_ctl[`LHS_LINK_PDN]) begin
          next_link_st = LINK_OFF;
        end else if (id_cnt == ID_WAIT - 8'h01) begin
          next_link_st = (part_id_s == EXPECTED_PART_ID)
                         ? LINK_UP : LINK_FAIL;
        end
      end
      LINK_UP: begin
        if (link_ctl[`LHS_LINK_PDN]) begin
          next_link_st = LINK_OFF;
        end
      end
      LINK_FAIL: next_link_st = LINK_FAIL;
      default:   next_link_st = LINK_OFF;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_st <= LINK_OFF;
      id_cnt  <= 8'h00;
    end else begin
      link_st <= next_link_st;
      id_cnt  <= next_id_cnt;
    end
  end

  assign link_up = (link_st == LINK_UP);
  assign seize   = link_up & term_ctl[`LHS_TERM_HOOK];

  // ----------------------------------------------------------------
  // off-hook settling
  // ----------------------------------------------------------------
  // counts sample periods, group delay included in the total
  always_comb begin
    next_hook_st    = hook_st;
    next_settle_cnt = settle_cnt;
    case (hook_st)
      HOOK_ON: begin
        next_settle_cnt = 11'h000;
        if (seize) begin
          next_hook_st = HOOK_SETTLE;
        end
      end
      HOOK_SETTLE: begin
        if (!seize) begin
          next_hook_st = HOOK_ON;
        end else if (sample_tick) begin
          next_settle_cnt = settle_cnt + 11'h001;
          if (settle_cnt == SETTLE_LAST) begin
            next_hook_st = HOOK_READY;
          end
        end
      end
      HOOK_READY: begin
        if (!seize) begin
          next_hook_st = HOOK_ON;
        end
      end
      default: next_hook_st = HOOK_ON;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hook_st    <= HOOK_ON;
      settle_cnt <= 11'h000;
    end else begin
      hook_st    <= next_hook_st;
      settle_cnt <= next_settle_cnt;
    end
  end

  // ----------------------------------------------------------------
  // line level sense
  // ----------------------------------------------------------------
  // source chosen by hook state, idle monitor and mode bits
  always_comb begin
    if (!link_up) begin
      sense_src = SRC_NONE;
    end else if (seize) begin
      sense_src = SRC_CURRENT;
    end else if (term_ctl[`LHS_TERM_IDLEMON]) begin
      sense_src = SRC_MONITOR;
    end else if (term_ctl[`LHS_TERM_MODE]) begin
      sense_src = SRC_VOLTAGE;
    end else begin
      sense_src = SRC_NONE;
    end
  end

  lhs_sense_coder u_coder (
    .line_voltage (line_voltage_s),
    .loop_current (loop_current_s),
    .monitor_data (monitor_data_s),
    .src          (sense_src),
    .euro_mode    (term_ctl[`LHS_TERM_DCT_HI:`LHS_TERM_DCT_LO]
                   == LHS_DCT_EURO),
    .code         (coder_out)
  );

  // refreshed every cycle
  always_comb begin
    next_sense_code = coder_out;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_code <= 5'h00;
    end else begin
      sense_code <= next_sense_code;
    end
  end

  // ----------------------------------------------------------------
  // registered line controls
  // ----------------------------------------------------------------
  // clamp only acts in the European mode
  always_comb begin
    next_outs[0]   = link_up;
    next_outs[1]   = (link_st == LINK_FAIL);
    next_outs[2]   = seize;
    next_outs[3]   = (hook_st == HOOK_READY) & seize;
    next_outs[4]   = term_ctl[`LHS_TERM_PAR];
    next_outs[5]   = term_ctl[`LHS_TERM_CLAMP]
                     & (term_ctl[`LHS_TERM_DCT_HI:`LHS_TERM_DCT_LO]
                        == LHS_DCT_EURO);
    next_outs[6]   = fs_ctl[`LHS_FS_FULL];
    next_outs[7]   = fs_ctl[`LHS_FS_HEADROOM];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      outs                <= 8'h00;
      dc_termination_mode <= LHS_DCT_FCC;
    end else begin
      outs                <= next_outs;
      dc_termination_mode <=
        term_ctl[`LHS_TERM_DCT_HI:`LHS_TERM_DCT_LO];
    end
  end

  assign link_enable          = outs[0];
  assign link_fault           = outs[1];
  assign hook_drive           = outs[2];
  assign line_data_valid      = outs[3];
  assign parallel_operation   = outs[4];
  assign current_clamp        = outs[5];
  assign full_scale_high      = outs[6];
  assign line_headroom_select = outs[7];
endmodule

// File: tb/lhs_line_chk.sv
`timescale 1ns/10ps
module lhs_line_chk import lhs_pkg::*; #(
  parameter logic [7:0] EXPECTED_PART_ID = 8'h5A // arbitrary value
) (
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // bus answer
  input wire logic       hreadyout,
  input wire logic       hresp,
  // line side
  input wire logic [7:0] part_id_pin,
  input wire logic       sample_tick,
  input wire logic       link_enable,
  input wire logic       link_fault,
  input wire logic       hook_drive,
  input wire logic       line_data_valid,
  input wire logic [1:0] dc_termination_mode,
  input wire logic       current_clamp
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------------------------------------------------------------
  // sample ticks seen while off-hook
  // ------------------------------------------------------------
  logic [11:0] ticks;
  logic [11:0] next_ticks;
  always_comb begin
    next_ticks = hook_drive ? ticks + {11'h000, sample_tick} : 12'h000;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ticks <= 12'h000;
    else ticks <= next_ticks;
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_link_id: assert property (
    $rose(link_enable) |-> part_id_pin == EXPECTED_PART_ID)
    else $error("link came up with a foreign part");
  a_fault_hold: assert property (link_fault |=> link_fault)
    else $error("identity fault cleared without reset");
  a_fault_dead: assert property (
    link_fault |-> !link_enable && !hook_drive)
    else $error("faulted link still working");
  a_hook_link: assert property ($rose(hook_drive) |-> link_enable)
    else $error("off-hook without link");
  a_valid_drop: assert property (
    $fell(hook_drive) |-> ##[0:2] !line_data_valid)
    else $error("line data stayed valid on-hook");
  a_valid_quiet: assert property (
    $rose(hook_drive) |=> !line_data_valid [*8])
    else $error("line data valid too early");
  a_settle_cnt: assert property (
    $rose(line_data_valid) |-> ticks >= 12'd1547 && ticks <= 12'd1548)
    else $error("settling tick count wrong");
  a_clamp_euro: assert property (
    current_clamp |-> dc_termination_mode == 2'b11)
    else $error("clamp outside european mode");
endmodule
bind lhs_line_ctrl lhs_line_chk #(.EXPECTED_PART_ID(EXPECTED_PART_ID)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .part_id_pin(part_id_pin), .sample_tick(sample_tick),
  .link_enable(link_enable), .link_fault(link_fault),
  .hook_drive(hook_drive), .line_data_valid(line_data_valid),
  .dc_termination_mode(dc_termination_mode),
  .current_clamp(current_clamp));

// File: tb/lhs_line_part.sv
`timescale 1ns/10ps
module lhs_line_part #(
  parameter logic [7:0] PART_ID = 8'h5A // arbitrary value
) (
  // clock
  input wire logic        hclk,
  // bench commands
  input wire logic        wrong_id,
  input wire logic        present,
  input wire logic [9:0]  v_q,
  input wire logic [9:0]  i_q,
  input wire logic [4:0]  mon,
  // hook from device
  input wire logic        hook_drive,
  // line part pins
  output logic [7:0]      part_id_pin,
  output logic            line_present_pin,
  output logic [9:0]      line_voltage_pin,
  output logic [9:0]      loop_current_pin,
  output logic [4:0]      monitor_data_pin,
  output logic            sample_tick
);
  logic [1:0] div = 2'h0;
  // sample rate at a quarter of the bus clock
  always_ff @(posedge hclk) div <= div + 2'h1;
  assign sample_tick      = (div == 2'h3);
  assign part_id_pin      = wrong_id ? ~PART_ID : PART_ID;
  assign line_present_pin = present;
  assign line_voltage_pin = v_q;
  // loop current flows only off-hook
  assign loop_current_pin = hook_drive ? i_q : 10'h000;
  assign monitor_data_pin = mon;
endmodule

// File: tb/tb.sv
`timescale 1ns/10ps
`include "lhs_defs.svh"
module tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        wrong_id, present, tick, line_present_pin;
  logic [1:0]  htrans, dc_termination_mode;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [9:0]  v_q, i_q, line_voltage_pin, loop_current_pin;
  logic [4:0]  mon, monitor_data_pin;
  logic [7:0]  part_id_pin;
  logic        link_enable, link_fault, hook_drive, line_data_valid;
  logic        parallel_operation, current_clamp, full_scale_high, headroom;
  int          fail_count, n_checks, c;
  time         t0;
  int          c_v[7] = '{11, 12, 22, 23, 100, 344, 400};
  int          c_i[6] = '{11, 12, 36, 359, 560, 561};
  lhs_line_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .part_id_pin(part_id_pin),
    .line_present_pin(line_present_pin),
    .line_voltage_pin(line_voltage_pin),
    .loop_current_pin(loop_current_pin),
    .monitor_data_pin(monitor_data_pin), .sample_tick(tick),
    .link_enable(link_enable), .link_fault(link_fault),
    .hook_drive(hook_drive), .line_data_valid(line_data_valid),
    .dc_termination_mode(dc_termination_mode),
    .parallel_operation(parallel_operation),
    .current_clamp(current_clamp), .full_scale_high(full_scale_high),
    .line_headroom_select(headroom));
  lhs_line_part i_part (.hclk(hclk), .wrong_id(wrong_id), .present(present),
    .v_q(v_q), .i_q(i_q), .mon(mon), .hook_drive(hook_drive),
    .part_id_pin(part_id_pin), .line_present_pin(line_present_pin),
    .line_voltage_pin(line_voltage_pin),
    .loop_current_pin(loop_current_pin),
    .monitor_data_pin(monitor_data_pin), .sample_tick(tick));
  // ------------------------------------------------------------
  // clock, compare, bus transfer
  // ------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge hclk);
    haddr <= {22'h000000, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // set a line level and read the sense code back
  task lvl(input logic [9:0] q, input logic [4:0] e);
    @(posedge hclk);
    v_q <= q;
    i_q <= q;
    repeat (6) @(posedge hclk);
    xfer(1'b0, `LHS_IDX_LEVEL, 8'h00);
    chk(rd[4:0], e);
  endtask
  function automatic logic [4:0] vcode(input int q);
    if (q < 12) return 5'h00;
    return ((q - 12) / 11 + 1 > 31) ? 5'h1F : 5'((q - 12) / 11 + 1);
  endfunction
  function automatic logic [4:0] icode(input int q, input bit eu);
    if (eu ? q > 216 : q > 560) return 5'h1F;
    return (q / 12 > 30) ? 5'h1E : 5'(q / 12);
  endfunction
  task conclude;
    $display("checks=%0d errors=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    conclude;
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {hsel, hsize, htrans, hwrite} = {1'b1, 3'b010, 3'b000};
    {haddr, hwdata} = 64'h0;
    {hresetn, wrong_id, present, v_q, i_q, mon} = 28'h0;
    {fail_count, n_checks} = 64'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, `LHS_IDX_TERM, 8'h00);
    chk(rd, 32'h08);
    xfer(1'b0, `LHS_IDX_FSCALE, 8'h00);
    chk(rd, 32'h00);
    xfer(1'b0, `LHS_IDX_LINK, 8'h00);
    chk(rd, 32'h01);
    xfer(1'b0, 8'hFF, 8'h00);
    chk(rd, 32'h00);
    repeat (150) @(posedge hclk);
    chk(link_enable, 1'b0);
    xfer(1'b1, `LHS_IDX_LINK, 8'h00);
    repeat (110) @(posedge hclk);
    chk(link_enable, 1'b1);
    xfer(1'b1, `LHS_IDX_FSCALE, 8'h03);
    repeat (2) @(posedge hclk);
    chk({full_scale_high, headroom}, 2'b11);
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, `LHS_IDX_TERM, {3'b000, 1'b1, 2'(m), 1'(m), 1'b0});
      repeat (2) @(posedge hclk);
      chk({parallel_operation, current_clamp, dc_termination_mode},
          {1'(m), m == 3, 2'(m)});
    end
    // on-hook voltage, monitor and idle readings
    xfer(1'b1, `LHS_IDX_TERM, 8'h48);
    foreach (c_v[k]) lvl(c_v[k], vcode(c_v[k]));
    chk(rd[7:5], 3'b100);
    xfer(1'b1, `LHS_IDX_TERM, 8'h08);
    lvl(10'd200, 5'h00);
    mon <= 5'h15;
    xfer(1'b1, `LHS_IDX_TERM, 8'h28);
    lvl(10'd200, 5'h15);
    xfer(1'b1, `LHS_IDX_LEVEL, 8'h1F);
    xfer(1'b0, `LHS_IDX_LEVEL, 8'h00);
    chk(rd[4:0], 5'h15);
    // off-hook, loop current and settling
    present <= 1'b1;
    xfer(1'b1, `LHS_IDX_TERM, 8'h09);
    t0 = $time;
    repeat (20) @(posedge hclk);
    chk({hook_drive, line_data_valid}, 2'b10);
    lvl(10'd0, 5'h00);
    chk(rd[5], 1'b1);
    foreach (c_i[k]) lvl(c_i[k], icode(c_i[k], 1'b0));
    xfer(1'b1, `LHS_IDX_TERM, 8'h0D);
    lvl(10'd216, icode(216, 1'b1));
    lvl(10'd217, icode(217, 1'b1));
    // host mode choices after off-hook, settling goes on meanwhile
    lvl(10'd36, 5'h03);
    xfer(1'b1, `LHS_IDX_TERM, 8'h09);
    xfer(1'b1, `LHS_IDX_FSCALE, 8'h02);
    xfer(1'b1, `LHS_IDX_TERM, 8'h01);
    lvl(10'd48, 5'h04);
    xfer(1'b1, `LHS_IDX_TERM, 8'h05);
    repeat (2) @(posedge hclk);
    chk({dc_termination_mode, headroom}, 3'b011);
    for (c = 0; c < 7000 && line_data_valid !== 1'b1; c++) @(posedge hclk);
    c = int'(($time - t0) / 10);
    chk(c >= 6180 && c <= 6200, 1'b1);
    xfer(1'b0, `LHS_IDX_LEVEL, 8'h00);
    chk(rd[6], 1'b1);
    xfer(1'b1, `LHS_IDX_TERM, 8'h09);
    repeat (2) @(posedge hclk);
    chk({hook_drive, dc_termination_mode}, 3'b110);
    xfer(1'b1, `LHS_IDX_TERM, 8'h08);
    repeat (3) @(posedge hclk);
    chk({hook_drive, line_data_valid}, 2'b00);
    // foreign part on the link
    wrong_id <= 1'b1;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b1, `LHS_IDX_LINK, 8'h00);
    repeat (110) @(posedge hclk);
    chk({link_fault, link_enable}, 2'b10);
    xfer(1'b1, `LHS_IDX_TERM, 8'h09);
    repeat (3) @(posedge hclk);
    chk(hook_drive, 1'b0);
    conclude;
  end
endmodule
